// *** acr_pkg.sv ***
// Package of constants and types for the converter trim and coefficient bank.
package acr_pkg;

  // ----------------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------------
  localparam int ACR_DATA_W      = 8;
  localparam int ACR_ADDR_W      = 8;
  localparam int ACR_IDX_W       = 3;
  localparam int ACR_CHAN_W      = 4;
  localparam int ACR_COEFF_BYTES = 6;
  localparam int ACR_ORDER0_W    = 15;
  localparam int ACR_ORDER1_W    = 14;
  localparam int ACR_ORDER2_W    = 14;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACR_AUX_CELL_OFFSET_TRIM    = 8'h4e;
  localparam logic [7:0] ACR_GENERAL_CHANNEL_GAIN    = 8'h4f;
  localparam logic [7:0] ACR_GENERAL_CHANNEL_OFFSET  = 8'h50;
  localparam logic [7:0] ACR_GAIN_COEFF_WORD1        = 8'h51;
  localparam logic [7:0] ACR_GAIN_COEFF_WORD2        = 8'h52;
  localparam logic [7:0] ACR_GAIN_COEFF_WORD3        = 8'h53;
  localparam logic [7:0] ACR_GAIN_COEFF_WORD4        = 8'h54;
  localparam logic [7:0] ACR_GAIN_COEFF_WORD5        = 8'h55;
  localparam logic [7:0] ACR_GAIN_COEFF_WORD6        = 8'h56;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACR_TRIM_RESET  = 8'h00;
  localparam logic [7:0] ACR_COEFF_RESET = 8'h00;
  localparam logic [7:0] ACR_READ_IDLE   = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions inside the coefficient words
  // ----------------------------------------------------------------------
  localparam int ACR_W2_ORDER0_POS = 0;
  localparam int ACR_W2_ORDER1_BIT = 7;
  localparam int ACR_W4_ORDER1_POS = 0;
  localparam int ACR_W4_ORDER2_POS = 5;
  localparam int ACR_W6_ORDER2_POS = 0;

  // ----------------------------------------------------------------------
  // Converter channel codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] ACR_CH_SELECTED_CELL = 4'h0;
  localparam logic [3:0] ACR_CH_PIN_FIRST     = 4'h1;
  localparam logic [3:0] ACR_CH_PIN_LAST      = 4'h6;

  // ----------------------------------------------------------------------
  // Coefficient assembly sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACR_SCAN_IDLE,
    ACR_SCAN_ISSUE,
    ACR_SCAN_CAPTURE
  } acr_scan_t;

endpackage : acr_pkg

// *** acr_coeff_mem.sv ***
// Small byte store holding the factory coefficient image.
`timescale 1ns/1ps
module acr_coeff_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 6,
  parameter int AW    = 3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;
  logic [WIDTH-1:0] rd_data_next;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en && (int'(wr_idx) < DEPTH)) begin
      mem_next[wr_idx] = wr_data;
    end
    rd_data_next = rd_data_reg;
    if (rd_en) begin
      rd_data_next = (int'(rd_idx) < DEPTH) ? mem_reg[rd_idx] : '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      rd_data_reg <= '0;
    end else begin
      mem_reg     <= mem_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

endmodule : acr_coeff_mem

// *** acr_trim_coeff_regs.sv ***
// Trim registers and gain coefficient bank of the auxiliary converter.
//
// Summary of operation
// - Trim at 0x4E corrects offset of channel code 0, the selected cell.
// - Gain trim at 0x4F serves every channel but selected cell and pins.
// - Offset trim at 0x50 serves every channel but selected cell and pins.
// - Word at 0x51 shows order-zero coefficient bits 7..0.
// - Word at 0x52 low seven bits show order-zero bits 14..8.
// - Word at 0x52 top bit shows order-one coefficient bit 0.
// - Word at 0x53 shows order-one coefficient bits 8..1.
// - Word at 0x54 low five bits show order-one bits 13..9.
// - Word at 0x54 top three bits show order-two bits 2..0.
// - Word at 0x55 shows order-two coefficient bits 10..3.
// - Word at 0x56 low three bits hold order-two bits 13..11.
`timescale 1ns/1ps
module acr_trim_coeff_regs
  import acr_pkg::*;
#(
  parameter int COEFF_BYTES = ACR_COEFF_BYTES
) (
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic [ACR_ADDR_W-1:0]   ADDR,
  input  wire logic [ACR_DATA_W-1:0]   WDATA,
  input  wire logic                    WR_STB,
  input  wire logic                    RD_STB,
  output logic      [ACR_DATA_W-1:0]   RDATA,
  input  wire logic                    FUSE_WE,
  input  wire logic [ACR_IDX_W-1:0]    FUSE_IDX,
  input  wire logic [ACR_DATA_W-1:0]   FUSE_DATA,
  input  wire logic                    FUSE_DONE,
  input  wire logic [ACR_CHAN_W-1:0]   CHAN_CODE,
  output logic      [ACR_DATA_W-1:0]   CORR_GAIN,
  output logic      [ACR_DATA_W-1:0]   CORR_OFFSET,
  output logic                         CORR_GAIN_EN,
  output logic                         CORR_OFFSET_EN,
  output logic      [ACR_ORDER0_W-1:0] COEFF_ORDER_ZERO,
  output logic      [ACR_ORDER1_W-1:0] COEFF_ORDER_ONE,
  output logic      [ACR_ORDER2_W-1:0] COEFF_ORDER_TWO,
  output logic                         COEFF_VALID
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [ACR_DATA_W-1:0]   aux_cell_offset_trim_reg;
  logic [ACR_DATA_W-1:0]   aux_cell_offset_trim_next;
  logic [ACR_DATA_W-1:0]   general_channel_gain_trim_reg;
  logic [ACR_DATA_W-1:0]   general_channel_gain_trim_next;
  logic [ACR_DATA_W-1:0]   general_channel_offset_trim_reg;
  logic [ACR_DATA_W-1:0]   general_channel_offset_trim_next;

  logic [ACR_DATA_W-1:0]   rdata_reg;
  logic [ACR_DATA_W-1:0]   rdata_next;

  logic [ACR_DATA_W-1:0]   corr_gain_reg;
  logic [ACR_DATA_W-1:0]   corr_gain_next;
  logic [ACR_DATA_W-1:0]   corr_offset_reg;
  logic [ACR_DATA_W-1:0]   corr_offset_next;
  logic                    corr_gain_en_reg;
  logic                    corr_gain_en_next;
  logic                    corr_offset_en_reg;
  logic                    corr_offset_en_next;

  acr_scan_t               scan_state_reg;
  acr_scan_t               scan_state_next;
  logic [ACR_IDX_W-1:0]    scan_idx_reg;
  logic [ACR_IDX_W-1:0]    scan_idx_next;
  logic                    pending_reg;
  logic                    pending_next;
  logic                    valid_reg;
  logic                    valid_next;
  logic [ACR_ORDER0_W-1:0] order_zero_reg;
  logic [ACR_ORDER0_W-1:0] order_zero_next;
  logic [ACR_ORDER1_W-1:0] order_one_reg;
  logic [ACR_ORDER1_W-1:0] order_one_next;
  logic [ACR_ORDER2_W-1:0] order_two_reg;
  logic [ACR_ORDER2_W-1:0] order_two_next;

  logic                    mem_rd_en;
  logic [ACR_DATA_W-1:0]   mem_rd_data;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Index of a coefficient word; only meaningful when is_coeff_addr holds.
  function automatic logic [ACR_IDX_W-1:0] coeff_index(
    input logic [ACR_ADDR_W-1:0] addr
  );
    logic [ACR_ADDR_W-1:0] diff;
    diff = addr - ACR_GAIN_COEFF_WORD1;
    return diff[ACR_IDX_W-1:0];
  endfunction : coeff_index

  function automatic logic is_coeff_addr(
    input logic [ACR_ADDR_W-1:0] addr
  );
    return (addr >= ACR_GAIN_COEFF_WORD1) &&
           (addr <= ACR_GAIN_COEFF_WORD6);
  endfunction : is_coeff_addr

  // ----------------------------------------------------------------------
  // Writable trims
  // ----------------------------------------------------------------------
  always_comb begin
    aux_cell_offset_trim_next        = aux_cell_offset_trim_reg;
    general_channel_gain_trim_next   = general_channel_gain_trim_reg;
    general_channel_offset_trim_next = general_channel_offset_trim_reg;
    if (WR_STB) begin
      // Coefficient words and unmapped offsets fall through untouched.
      case (ADDR)
        ACR_AUX_CELL_OFFSET_TRIM: begin
          aux_cell_offset_trim_next = WDATA;
        end
        ACR_GENERAL_CHANNEL_GAIN: begin
          general_channel_gain_trim_next = WDATA;
        end
        ACR_GENERAL_CHANNEL_OFFSET: begin
          general_channel_offset_trim_next = WDATA;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aux_cell_offset_trim_reg        <= ACR_TRIM_RESET;
      general_channel_gain_trim_reg   <= ACR_TRIM_RESET;
      general_channel_offset_trim_reg <= ACR_TRIM_RESET;
    end else begin
      aux_cell_offset_trim_reg        <= aux_cell_offset_trim_next;
      general_channel_gain_trim_reg   <= general_channel_gain_trim_next;
      general_channel_offset_trim_reg <= general_channel_offset_trim_next;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Coefficient words are rebuilt from the assembled coefficients, so a
  // read returns what the converter was being handed in the strobe cycle.
  always_comb begin
    rdata_next = ACR_READ_IDLE;
    if (RD_STB) begin
      case (ADDR)
        ACR_AUX_CELL_OFFSET_TRIM: begin
          rdata_next = aux_cell_offset_trim_reg;
        end
        ACR_GENERAL_CHANNEL_GAIN: begin
          rdata_next = general_channel_gain_trim_reg;
        end
        ACR_GENERAL_CHANNEL_OFFSET: begin
          rdata_next = general_channel_offset_trim_reg;
        end
        ACR_GAIN_COEFF_WORD1: begin
          rdata_next = order_zero_reg[7:0];
        end
        ACR_GAIN_COEFF_WORD2: begin
          rdata_next = {order_one_reg[0], order_zero_reg[14:8]};
        end
        ACR_GAIN_COEFF_WORD3: begin
          rdata_next = order_one_reg[8:1];
        end
        ACR_GAIN_COEFF_WORD4: begin
          rdata_next = {order_two_reg[2:0], order_one_reg[13:9]};
        end
        ACR_GAIN_COEFF_WORD5: begin
          rdata_next = order_two_reg[10:3];
        end
        ACR_GAIN_COEFF_WORD6: begin
          // Upper five bits belong to a coefficient outside this bank.
          rdata_next = {5'h00, order_two_reg[13:11]};
        end
        default: begin
          rdata_next = ACR_READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= ACR_READ_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel correction selection
  // ----------------------------------------------------------------------
  // The pin inputs and the selected cell gain use trims kept elsewhere;
  // the enables tell the converter that this bank has nothing for them.
  always_comb begin
    corr_gain_next      = ACR_TRIM_RESET;
    corr_offset_next    = ACR_TRIM_RESET;
    corr_gain_en_next   = 1'b0;
    corr_offset_en_next = 1'b0;
    if (CHAN_CODE == ACR_CH_SELECTED_CELL) begin
      corr_offset_next    = aux_cell_offset_trim_reg;
      corr_offset_en_next = 1'b1;
    end else if ((CHAN_CODE >= ACR_CH_PIN_FIRST) &&
                 (CHAN_CODE <= ACR_CH_PIN_LAST)) begin
      corr_gain_en_next   = 1'b0;
      corr_offset_en_next = 1'b0;
    end else begin
      corr_gain_next      = general_channel_gain_trim_reg;
      corr_gain_en_next   = 1'b1;
      corr_offset_next    = general_channel_offset_trim_reg;
      corr_offset_en_next = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      corr_gain_reg      <= ACR_TRIM_RESET;
      corr_offset_reg    <= ACR_TRIM_RESET;
      corr_gain_en_reg   <= 1'b0;
      corr_offset_en_reg <= 1'b0;
    end else begin
      corr_gain_reg      <= corr_gain_next;
      corr_offset_reg    <= corr_offset_next;
      corr_gain_en_reg   <= corr_gain_en_next;
      corr_offset_en_reg <= corr_offset_en_next;
    end
  end

  // ----------------------------------------------------------------------
  // Coefficient assembly from the factory image
  // ----------------------------------------------------------------------
  // After reset and after every completed image load the sequencer walks
  // the image one byte at a time. A load that starts mid-walk drops the
  // valid flag and leaves a request pending, so the walk runs again.
  always_comb begin
    scan_state_next = scan_state_reg;
    scan_idx_next   = scan_idx_reg;
    pending_next    = pending_reg;
    valid_next      = valid_reg;
    order_zero_next = order_zero_reg;
    order_one_next  = order_one_reg;
    order_two_next  = order_two_reg;
    mem_rd_en       = 1'b0;
    case (scan_state_reg)
      ACR_SCAN_IDLE: begin
        if (pending_reg && !FUSE_WE) begin
          pending_next    = 1'b0;
          valid_next      = 1'b0;
          scan_idx_next   = '0;
          scan_state_next = ACR_SCAN_ISSUE;
        end
      end
      ACR_SCAN_ISSUE: begin
        mem_rd_en       = 1'b1;
        scan_state_next = ACR_SCAN_CAPTURE;
      end
      ACR_SCAN_CAPTURE: begin
        case (scan_idx_reg)
          3'h0: begin
            order_zero_next[7:0] = mem_rd_data;
          end
          3'h1: begin
            order_zero_next[14:8] =
              mem_rd_data[ACR_W2_ORDER0_POS +: 7];
            order_one_next[0] = mem_rd_data[ACR_W2_ORDER1_BIT];
          end
          3'h2: begin
            order_one_next[8:1] = mem_rd_data;
          end
          3'h3: begin
            order_one_next[13:9] =
              mem_rd_data[ACR_W4_ORDER1_POS +: 5];
            order_two_next[2:0] =
              mem_rd_data[ACR_W4_ORDER2_POS +: 3];
          end
          3'h4: begin
            order_two_next[10:3] = mem_rd_data;
          end
          3'h5: begin
            order_two_next[13:11] =
              mem_rd_data[ACR_W6_ORDER2_POS +: 3];
          end
          default: begin
          end
        endcase
        if (int'(scan_idx_reg) == COEFF_BYTES - 1) begin
          valid_next      = !pending_reg;
          scan_state_next = ACR_SCAN_IDLE;
        end else begin
          scan_idx_next   = scan_idx_reg + 3'h1;
          scan_state_next = ACR_SCAN_ISSUE;
        end
      end
      default: begin
        scan_state_next = ACR_SCAN_IDLE;
      end
    endcase
    // A load strobe wins over a set of the valid flag in the same cycle.
    if (FUSE_WE) begin
      valid_next = 1'b0;
    end
    if (FUSE_DONE) begin
      pending_next = 1'b1;
      valid_next   = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      scan_state_reg <= ACR_SCAN_IDLE;
      scan_idx_reg   <= '0;
      pending_reg    <= 1'b1;
      valid_reg      <= 1'b0;
      order_zero_reg <= '0;
      order_one_reg  <= '0;
      order_two_reg  <= '0;
    end else begin
      scan_state_reg <= scan_state_next;
      scan_idx_reg   <= scan_idx_next;
      pending_reg    <= pending_next;
      valid_reg      <= valid_next;
      order_zero_reg <= order_zero_next;
      order_one_reg  <= order_one_next;
      order_two_reg  <= order_two_next;
    end
  end

  // ----------------------------------------------------------------------
  // Factory image store
  // ----------------------------------------------------------------------
  // Only the image load port writes here; the register bus cannot.
  acr_coeff_mem #(
    .WIDTH (ACR_DATA_W),
    .DEPTH (COEFF_BYTES),
    .AW    (ACR_IDX_W)
  ) u_coeff_mem (
    .clk     (CLK),
    .rst     (RST),
    .wr_en   (FUSE_WE),
    .wr_idx  (FUSE_IDX),
    .wr_data (FUSE_DATA),
    .rd_en   (mem_rd_en),
    .rd_idx  (scan_idx_reg),
    .rd_data (mem_rd_data)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign RDATA            = rdata_reg;
  assign CORR_GAIN        = corr_gain_reg;
  assign CORR_OFFSET      = corr_offset_reg;
  assign CORR_GAIN_EN     = corr_gain_en_reg;
  assign CORR_OFFSET_EN   = corr_offset_en_reg;
  assign COEFF_ORDER_ZERO = order_zero_reg;
  assign COEFF_ORDER_ONE  = order_one_reg;
  assign COEFF_ORDER_TWO  = order_two_reg;
  assign COEFF_VALID      = valid_reg;

endmodule : acr_trim_coeff_regs

// *** acr_trim_coeff_regs_assertions.sv ***
// Checker for the converter trim and coefficient bank, with its bind.
`timescale 1ns/1ps
module acr_trim_coeff_regs_chk
  import acr_pkg::*;
#(
  parameter int COEFF_BYTES = ACR_COEFF_BYTES
) (
  input wire logic                    CLK,
  input wire logic                    RST,
  input wire logic [ACR_ADDR_W-1:0]   ADDR,
  input wire logic [ACR_DATA_W-1:0]   WDATA,
  input wire logic                    WR_STB,
  input wire logic                    RD_STB,
  input wire logic [ACR_DATA_W-1:0]   RDATA,
  input wire logic                    FUSE_WE,
  input wire logic [ACR_IDX_W-1:0]    FUSE_IDX,
  input wire logic [ACR_DATA_W-1:0]   FUSE_DATA,
  input wire logic                    FUSE_DONE,
  input wire logic [ACR_CHAN_W-1:0]   CHAN_CODE,
  input wire logic [ACR_DATA_W-1:0]   CORR_GAIN,
  input wire logic [ACR_DATA_W-1:0]   CORR_OFFSET,
  input wire logic                    CORR_GAIN_EN,
  input wire logic                    CORR_OFFSET_EN,
  input wire logic [ACR_ORDER0_W-1:0] COEFF_ORDER_ZERO,
  input wire logic [ACR_ORDER1_W-1:0] COEFF_ORDER_ONE,
  input wire logic [ACR_ORDER2_W-1:0] COEFF_ORDER_TWO,
  input wire logic                    COEFF_VALID
);
  // ----------------------------------------------------------------------
  // Edges since reset release
  // ----------------------------------------------------------------------
  // The correction outputs are zero for the first edges after release, so
  // the channel checks wait until the pipeline has seen a real code.
  logic [1:0] age_reg;
  logic [1:0] age_next;

  always_comb begin
    age_next = age_reg;
    if (age_reg != 2'h3) age_next = age_reg + 2'h1;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) age_reg <= 2'h0;
    else age_reg <= age_next;
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Valid on both sides means no walk touched the coefficients between.
  sequence rd_at(logic [7:0] a);
    RD_STB && COEFF_VALID && ADDR == a ##1 COEFF_VALID;
  endsequence

  rdata_idle_a: assert property (!$past(RD_STB) |-> RDATA == 8'h00)
    else $error("read data not idle");
  unmapped_zero_a: assert property (RD_STB && !(ADDR inside
    {[8'h4e:8'h56]}) |=> RDATA == 8'h00) else $error("unmapped read");
  cell_corr_a: assert property (age_reg == 2'h3 &&
    $past(CHAN_CODE) == 4'h0 |-> CORR_OFFSET_EN && !CORR_GAIN_EN &&
    CORR_GAIN == 8'h00)
    else $error("cell correction wrong");
  pin_corr_a: assert property (age_reg == 2'h3 &&
    $past(CHAN_CODE) inside {[4'h1:4'h6]} |-> !CORR_OFFSET_EN &&
    !CORR_GAIN_EN && CORR_GAIN == 8'h00 && CORR_OFFSET == 8'h00)
    else $error("pin correction wrong");
  general_corr_a: assert property (age_reg == 2'h3 &&
    $past(CHAN_CODE) >= 4'h7 |-> CORR_GAIN_EN && CORR_OFFSET_EN)
    else $error("general correction off");
  word_one_a: assert property (rd_at(8'h51) |->
    RDATA == COEFF_ORDER_ZERO[7:0]) else $error("word 0x51 wrong");
  word_two_a: assert property (rd_at(8'h52) |-> RDATA ==
    {COEFF_ORDER_ONE[0], COEFF_ORDER_ZERO[14:8]})
    else $error("word 0x52 wrong");
  word_three_a: assert property (rd_at(8'h53) |->
    RDATA == COEFF_ORDER_ONE[8:1]) else $error("word 0x53 wrong");
  word_four_a: assert property (rd_at(8'h54) |-> RDATA ==
    {COEFF_ORDER_TWO[2:0], COEFF_ORDER_ONE[13:9]})
    else $error("word 0x54 wrong");
  word_five_a: assert property (rd_at(8'h55) |->
    RDATA == COEFF_ORDER_TWO[10:3]) else $error("word 0x55 wrong");
  word_six_a: assert property (rd_at(8'h56) |->
    RDATA == {5'h00, COEFF_ORDER_TWO[13:11]}) else $error("0x56 wrong");
  ro_write_a: assert property (WR_STB && ADDR inside {[8'h51:8'h56]} &&
    COEFF_VALID && !FUSE_WE && !FUSE_DONE |=> COEFF_VALID &&
    $stable(COEFF_ORDER_ZERO) && $stable(COEFF_ORDER_ONE) &&
    $stable(COEFF_ORDER_TWO)) else $error("read-only word changed");

  cover property (rd_at(8'h56));
  cover property (FUSE_DONE ##[1:20] COEFF_VALID);
  cover property (age_reg == 2'h3 && $past(CHAN_CODE) == 4'h0);
endmodule : acr_trim_coeff_regs_chk

bind acr_trim_coeff_regs acr_trim_coeff_regs_chk #(
  .COEFF_BYTES(COEFF_BYTES)
) i_acr_trim_coeff_regs_chk (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
  .RD_STB(RD_STB), .RDATA(RDATA), .FUSE_WE(FUSE_WE), .FUSE_IDX(FUSE_IDX),
  .FUSE_DATA(FUSE_DATA), .FUSE_DONE(FUSE_DONE), .CHAN_CODE(CHAN_CODE),
  .CORR_GAIN(CORR_GAIN), .CORR_OFFSET(CORR_OFFSET),
  .CORR_GAIN_EN(CORR_GAIN_EN), .CORR_OFFSET_EN(CORR_OFFSET_EN),
  .COEFF_ORDER_ZERO(COEFF_ORDER_ZERO), .COEFF_ORDER_ONE(COEFF_ORDER_ONE),
  .COEFF_ORDER_TWO(COEFF_ORDER_TWO), .COEFF_VALID(COEFF_VALID)
);

// *** test_acr_trim_coeff_regs.sv ***
// Self-checking bench for the converter trim and coefficient bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_acr_trim_coeff_regs
  import acr_pkg::*;
;
  logic        CLK, RST, WR_STB, RD_STB, FUSE_WE, FUSE_DONE;
  logic [7:0]  ADDR, WDATA, RDATA, FUSE_DATA, CORR_GAIN, CORR_OFFSET;
  logic [2:0]  FUSE_IDX;
  logic [3:0]  CHAN_CODE;
  logic        CORR_GAIN_EN, CORR_OFFSET_EN, COEFF_VALID;
  logic [17:0] corr_got;
  logic [14:0] COEFF_ORDER_ZERO;
  logic [13:0] COEFF_ORDER_ONE, COEFF_ORDER_TWO;
  int          bad_count, checked, k;
  int          seed = 32'h338b507c;
  logic [7:0]  trim [3];
  logic [7:0]  img [6];

  acr_trim_coeff_regs #(.COEFF_BYTES(ACR_COEFF_BYTES)) i_acr_trim_coeff_regs (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .RDATA(RDATA), .FUSE_WE(FUSE_WE), .FUSE_IDX(FUSE_IDX),
    .FUSE_DATA(FUSE_DATA), .FUSE_DONE(FUSE_DONE), .CHAN_CODE(CHAN_CODE),
    .CORR_GAIN(CORR_GAIN), .CORR_OFFSET(CORR_OFFSET),
    .CORR_GAIN_EN(CORR_GAIN_EN), .CORR_OFFSET_EN(CORR_OFFSET_EN),
    .COEFF_ORDER_ZERO(COEFF_ORDER_ZERO), .COEFF_ORDER_ONE(COEFF_ORDER_ONE),
    .COEFF_ORDER_TWO(COEFF_ORDER_TWO), .COEFF_VALID(COEFF_VALID));

  always #25 CLK = ~CLK;

  // ----------------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------------
  function automatic logic [17:0] corr_exp(input logic [3:0] c);
    if (c == 4'h0) return {2'b01, 8'h00, trim[0]};
    if (c <= 4'h6) return 18'h00000;
    return {2'b11, trim[1], trim[2]};
  endfunction : corr_exp

  function automatic logic [7:0] word_exp(input int i, input logic [14:0] z,
                                          input logic [13:0] o, t);
    case (i)
      0: return z[7:0];
      1: return {o[0], z[14:8]};
      2: return o[8:1];
      3: return {t[2:0], o[13:9]};
      4: return t[10:3];
      default: return {5'h00, t[13:11]};
    endcase
  endfunction : word_exp

  task automatic end_sim;
    $display("Counts: checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // A strobe stands until the next call, so calls run back to back.
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    @(posedge CLK);
    WR_STB <= w;
    RD_STB <= r;
    ADDR   <= a;
    WDATA  <= d;
  endtask : bus

  task automatic rd(input logic [7:0] a, exp);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    `CHK(RDATA, exp)
  endtask : rd

  task automatic wait_valid;
    for (int n = 0; n < 40 && COEFF_VALID !== 1'b1; n++) begin
      @(posedge CLK);
      #1;
    end
    if (COEFF_VALID !== 1'b1) begin
      bad_count++;
      end_sim();
    end
  endtask : wait_valid

  task automatic check_coeff;
    logic [14:0] z;
    logic [13:0] o, t;
    z = {img[1][6:0], img[0]};
    o = {img[3][4:0], img[2], img[1][7]};
    t = {img[5][2:0], img[4], img[3][7:5]};
    `CHK(COEFF_ORDER_ZERO, z)
    `CHK(COEFF_ORDER_ONE, o)
    `CHK(COEFF_ORDER_TWO, t)
    for (int i = 0; i < 6; i++) begin
      rd(8'h51 + i[7:0], word_exp(i, z, o, t));
    end
  endtask : check_coeff

  // The last byte carries the done pulse too, the tightest legal order.
  task automatic load;
    for (int i = 0; i < 6; i++) begin
      @(posedge CLK);
      FUSE_WE   <= 1'b1;
      FUSE_IDX  <= i[2:0];
      FUSE_DATA <= img[i];
      FUSE_DONE <= (i == 5);
    end
    @(posedge CLK);
    FUSE_WE   <= 1'b0;
    FUSE_DONE <= 1'b0;
    wait_valid();
    check_coeff();
  endtask : load

  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    CLK = 1'b0; RST = 1'b1; WR_STB = 1'b0; RD_STB = 1'b0;
    ADDR = 8'h00; WDATA = 8'h00; FUSE_WE = 1'b0; FUSE_IDX = 3'h0;
    FUSE_DATA = 8'h00; FUSE_DONE = 1'b0; CHAN_CODE = 4'h0;
    bad_count = 0; checked = 0;
    trim = '{default: 8'h00};
    img = '{default: 8'h00};
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    wait_valid();
    check_coeff();
    for (int a = 0; a < 3; a++) rd(8'h4e + a[7:0], 8'h00);
    rd(8'h4d, 8'h00);
    rd(8'h57, 8'h00);
    for (int i = 0; i < 6; i++) img[i] = 8'($random(seed));
    load();
    img = '{default: 8'hff};
    load();
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 1'b0, 8'h51 + i[7:0], 8'($random(seed)));
    end
    check_coeff();
    repeat (12) begin
      k = {$random(seed)} % 3;
      trim[k] = 8'($random(seed));
      bus(1'b1, 1'b0, 8'h4e + k[7:0], trim[k]);
      rd(8'h4e + k[7:0], trim[k]);
    end
    bus(1'b1, 1'b0, 8'h57, 8'hff);
    rd(8'h57, 8'h00);
    for (int c = 0; c < 16; c++) begin
      @(posedge CLK);
      CHAN_CODE <= c[3:0];
      repeat (2) @(posedge CLK);
      #1;
      corr_got = {CORR_GAIN_EN, CORR_OFFSET_EN, CORR_GAIN, CORR_OFFSET};
      `CHK(corr_got, corr_exp(c[3:0]))
    end
    // A second done pulse in mid-walk must make the walk run again once it ends.
    @(posedge CLK);
    FUSE_DONE <= 1'b1;
    @(posedge CLK);
    FUSE_DONE <= 1'b0;
    repeat (4) @(posedge CLK);
    FUSE_DONE <= 1'b1;
    @(posedge CLK);
    FUSE_DONE <= 1'b0;
    #1;
    `CHK(COEFF_VALID, 1'b0)
    wait_valid();
    check_coeff();
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    img = '{default: 8'h00};
    wait_valid();
    check_coeff();
    rd(8'h4f, 8'h00);
    end_sim();
  end
endmodule : test_acr_trim_coeff_regs
